// ---- deep_stop_power_sequencer.sv ----
// stop-mode sequencer: stop entry, deep-stop wake, restart, pin latches and clock gating
//
// Functional notes
// - ram-retaining deep stop powers off core like deepest stop but keeps ram.
// - entering ram-retaining deep stop latches all pin controls for the whole stop.
// - in ram-retaining deep stop, low wake pin ends the stop regardless of config.
// - in deepest stop, low wake pin ends the stop regardless of config.
// - wake pin pull-up is disabled in both deep stop modes.
// - enabled periodic wake timer event also ends ram-retaining deep stop.
// - enabled periodic wake timer event also ends deepest stop.
// - deep-stop wake restarts the device as from power-on reset.
// - after wake, low-voltage reset on, low trip, held while supply low.
// - ram-retain wake sets partial flag; flag and latches hold until acknowledge.
// - deepest wake sets powerdown flag, held until acknowledge written with one.
// - opening latches gives pins their current port register values, or peripheral values where a peripheral is enabled.
// - on opening, pins of disabled peripherals follow port control registers.
// - entering deepest stop puts every pin straight to high impedance.
// - deepest stop powers off everything, ram and regulator included.
// - every stop mode gates peripheral clocks, even with debug enabled.
// - light stop keeps converter only with async clock and detector enabled.
// - light stop keeps internal reference only with clock and stop enables.
// - light stop keeps oscillator with enables; high range also needs detector.
// - powerdown control selects deep stop; partial control picks ram retention.
// - stop with stop enable clear gives illegal-opcode reset, no stop.
`timescale 1ns/100ps

module deep_stop_power_sequencer #(
    parameter int N_PINS = deep_stop_pkg::PIN_COUNT,
    parameter int RESTART_CYCLES = deep_stop_pkg::RESTART_CYCLES
) (
    // clock and power-on reset
    input wire logic i_clk,
    input wire logic i_srst,
    // stop request and mode selection
    input wire logic i_stop_execute,
    input wire logic i_stop_instruction_enable,
    input wire logic i_powerdown_control,
    input wire logic i_partial_powerdown_control,
    input wire deep_stop_pkg::stop_cfg_t i_stop_cfg,
    // wake sources
    input wire logic i_wake_pin_n,
    input wire logic i_wake_pin_pullup_request,
    input wire logic i_periodic_wake_timer_event,
    input wire logic i_periodic_wake_timer_irq_enable,
    input wire logic i_light_stop_wake,
    input wire logic i_low_voltage_detector_low,
    // acknowledge write
    input wire logic i_powerdown_acknowledge_write,
    input wire logic i_powerdown_acknowledge_data,
    // pin sources
    input wire logic [N_PINS-1:0] i_port_data,
    input wire logic [N_PINS-1:0] i_port_direction,
    input wire logic [N_PINS-1:0] i_periph_enable,
    input wire logic [N_PINS-1:0] i_periph_data,
    input wire logic [N_PINS-1:0] i_periph_direction,
    // mode and reset outputs
    output logic [2:0] o_mode,
    output logic o_system_reset,
    output logic o_illegal_opcode_reset,
    output logic o_lvd_reset_enable,
    output logic o_lvd_low_trip_select,
    // status flags
    output logic o_partial_powerdown_flag,
    output logic o_powerdown_flag,
    output logic o_powerdown_acknowledge,
    output logic o_pin_latch_closed,
    // power and clock controls
    output deep_stop_pkg::power_ctl_t o_power_ctl,
    output logic o_wake_pin_pullup_enable,
    // pins
    output logic [N_PINS-1:0] o_pin_out,
    output logic [N_PINS-1:0] o_pin_oe_n
);

    // elaboration check
    if (N_PINS < 1 || RESTART_CYCLES < 1 ||
        RESTART_CYCLES >= (1 << deep_stop_pkg::RESTART_CNT_W))
    begin : g_bad_param
        $error("deep_stop_power_sequencer: unsupported parameter value");
    end

    localparam logic [deep_stop_pkg::RESTART_CNT_W-1:0] RESTART_LAST =
        deep_stop_pkg::RESTART_CNT_W'(RESTART_CYCLES - 1);

    // whole module state
    typedef struct packed {
        deep_stop_pkg::power_mode_t mode;
        deep_stop_pkg::stop_cfg_t cfg;
        logic [deep_stop_pkg::RESTART_CNT_W-1:0] restart_cnt;
        logic wake_meta;
        logic wake_sync;
        logic lvd_meta;
        logic lvd_sync;
        logic illegal_reset;
        logic partial_flag;
        logic full_flag;
        logic latched;
        logic [N_PINS-1:0] hold_out;
        logic [N_PINS-1:0] hold_oe_n;
        logic system_reset;
        deep_stop_pkg::power_ctl_t power;
        logic pullup_enable;
        logic [N_PINS-1:0] pin_out;
        logic [N_PINS-1:0] pin_oe_n;
    } seq_state_t;

    seq_state_t cur;
    seq_state_t next_state;

    // next-state logic
    always_comb
    begin
        logic deep_wake;
        logic restart_done;
        logic [N_PINS-1:0] live_out;
        logic [N_PINS-1:0] live_oe_n;
        deep_wake = 1'b0;
        restart_done = 1'b0;
        live_out = '0;
        live_oe_n = '1;
        next_state = cur;
        next_state.illegal_reset = 1'b0;

        // two-stage synchronisers for pin and detector levels
        next_state.wake_meta = i_wake_pin_n;
        next_state.wake_sync = cur.wake_meta;
        next_state.lvd_meta = i_low_voltage_detector_low;
        next_state.lvd_sync = cur.lvd_meta;

        // acknowledge: only a one acts, clear loses to a same-cycle set below
        if (cur.mode == deep_stop_pkg::mode_run && i_powerdown_acknowledge_write &&
            i_powerdown_acknowledge_data)
        begin
            next_state.partial_flag = 1'b0;
            next_state.full_flag = 1'b0;
            next_state.latched = 1'b0;
        end

        // wake from either deep stop: low wake pin or enabled timer event
        deep_wake = !cur.wake_sync ||
            (i_periodic_wake_timer_event && i_periodic_wake_timer_irq_enable);
        restart_done = (cur.restart_cnt == RESTART_LAST);

        // mode sequencing
        unique case (cur.mode)
            deep_stop_pkg::mode_run:
            begin
                if (i_stop_execute)
                begin
                    if (!i_stop_instruction_enable)
                    begin
                        next_state.illegal_reset = 1'b1;
                    end
                    else
                    begin
                        next_state.cfg = i_stop_cfg;
                        if (i_stop_cfg.background_debug_enable ||
                            (i_stop_cfg.low_voltage_detector_enable &&
                             i_stop_cfg.low_voltage_detector_stop_enable) ||
                            !i_powerdown_control)
                        begin
                            next_state.mode = deep_stop_pkg::mode_light_stop;
                        end
                        else if (i_partial_powerdown_control)
                        begin
                            next_state.mode = deep_stop_pkg::mode_ram_retain_stop;
                            next_state.latched = 1'b1;
                            next_state.hold_out = cur.pin_out;
                            next_state.hold_oe_n = cur.pin_oe_n;
                        end
                        else
                        begin
                            next_state.mode = deep_stop_pkg::mode_deepest_stop;
                        end
                    end
                end
            end
            deep_stop_pkg::mode_light_stop:
            begin
                if (i_light_stop_wake)
                begin
                    next_state.mode = deep_stop_pkg::mode_run;
                end
            end
            deep_stop_pkg::mode_ram_retain_stop:
            begin
                if (deep_wake)
                begin
                    next_state.mode = deep_stop_pkg::mode_restart;
                    next_state.restart_cnt = '0;
                    next_state.partial_flag = 1'b1;
                end
            end
            deep_stop_pkg::mode_deepest_stop:
            begin
                if (deep_wake)
                begin
                    next_state.mode = deep_stop_pkg::mode_restart;
                    next_state.restart_cnt = '0;
                    next_state.full_flag = 1'b1;
                end
            end
            deep_stop_pkg::mode_restart:
            begin
                if (!restart_done)
                begin
                    next_state.restart_cnt = cur.restart_cnt + 1'b1;
                end
                else if (!cur.lvd_sync)
                begin
                    next_state.mode = deep_stop_pkg::mode_run;
                end
            end
            default:
            begin
                next_state.mode = deep_stop_pkg::mode_restart;
                next_state.restart_cnt = '0;
            end
        endcase

        // restart holds the device in reset
        next_state.system_reset = (next_state.mode == deep_stop_pkg::mode_restart);

        // power and clock controls from the coming mode
        next_state.power = deep_stop_pkg::POWER_CTL_RESET;
        next_state.pullup_enable = i_wake_pin_pullup_request;
        unique case (next_state.mode)
            deep_stop_pkg::mode_light_stop:
            begin
                next_state.power.periph_clock_enable = 1'b0;
                next_state.power.debug_clock_enable =
                    next_state.cfg.background_debug_enable;
                next_state.power.core_power = 1'b1;
                next_state.power.regulator_full = next_state.cfg.background_debug_enable ||
                    (next_state.cfg.low_voltage_detector_enable &&
                     next_state.cfg.low_voltage_detector_stop_enable);
                next_state.power.converter_run =
                    next_state.cfg.converter_async_clock_enable &&
                    next_state.cfg.low_voltage_detector_enable &&
                    next_state.cfg.low_voltage_detector_stop_enable;
                next_state.power.internal_ref_run =
                    next_state.cfg.internal_ref_clock_enable &&
                    next_state.cfg.internal_ref_stop_enable;
                next_state.power.external_osc_run =
                    next_state.cfg.external_ref_clock_enable &&
                    next_state.cfg.external_ref_stop_enable &&
                    (!next_state.cfg.external_high_range ||
                     (next_state.cfg.low_voltage_detector_enable &&
                      next_state.cfg.low_voltage_detector_stop_enable));
            end
            deep_stop_pkg::mode_ram_retain_stop:
            begin
                next_state.power.periph_clock_enable = 1'b0;
                next_state.power.debug_clock_enable = 1'b0;
                next_state.power.core_power = 1'b0;
                next_state.power.regulator_full = 1'b0;
                next_state.pullup_enable = 1'b0;
            end
            deep_stop_pkg::mode_deepest_stop:
            begin
                next_state.power.periph_clock_enable = 1'b0;
                next_state.power.debug_clock_enable = 1'b0;
                next_state.power.core_power = 1'b0;
                next_state.power.ram_power = 1'b0;
                next_state.power.regulator_power = 1'b0;
                next_state.power.regulator_full = 1'b0;
                next_state.pullup_enable = 1'b0;
            end
            deep_stop_pkg::mode_restart:
            begin
                next_state.power.periph_clock_enable = 1'b0;
                next_state.pullup_enable = 1'b1;
            end
            default:
            begin
                next_state.power.converter_run = 1'b1;
                next_state.power.internal_ref_run = i_stop_cfg.internal_ref_clock_enable;
                next_state.power.external_osc_run = i_stop_cfg.external_ref_clock_enable;
            end
        endcase

        // pin drive: peripheral owns the pin when enabled, else port registers
        live_out = (i_periph_enable & i_periph_data) | (~i_periph_enable & i_port_data);
        live_oe_n = ~((i_periph_enable & i_periph_direction) |
            (~i_periph_enable & i_port_direction));
        if (next_state.mode == deep_stop_pkg::mode_deepest_stop)
        begin
            next_state.pin_out = '0;
            next_state.pin_oe_n = '1;
        end
        else if (next_state.latched)
        begin
            next_state.pin_out = next_state.hold_out;
            next_state.pin_oe_n = next_state.hold_oe_n;
        end
        else
        begin
            next_state.pin_out = live_out;
            next_state.pin_oe_n = live_oe_n;
        end
    end

    // state register, power-on reset
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cur <= '0;
            cur.mode <= deep_stop_pkg::mode_run;
            cur.wake_meta <= 1'b1;
            cur.wake_sync <= 1'b1;
            cur.partial_flag <= deep_stop_pkg::FLAG_RESET;
            cur.full_flag <= deep_stop_pkg::FLAG_RESET;
            cur.latched <= deep_stop_pkg::LATCH_RESET;
            cur.hold_oe_n <= '1;
            cur.power <= deep_stop_pkg::POWER_CTL_RESET;
            cur.pullup_enable <= 1'b1;
            cur.pin_oe_n <= '1;
        end
        else
        begin
            cur <= next_state;
        end
    end

    // outputs straight from the state register, except the constant acknowledge read value
    assign o_mode = cur.mode;
    assign o_system_reset = cur.system_reset;
    assign o_illegal_opcode_reset = cur.illegal_reset;
    assign o_lvd_reset_enable = cur.system_reset;
    assign o_lvd_low_trip_select = cur.system_reset;
    assign o_partial_powerdown_flag = cur.partial_flag;
    assign o_powerdown_flag = cur.full_flag;
    assign o_powerdown_acknowledge = deep_stop_pkg::ACK_READ_VALUE;
    assign o_pin_latch_closed = cur.latched;
    assign o_power_ctl = cur.power;
    assign o_wake_pin_pullup_enable = cur.pullup_enable;
    assign o_pin_out = cur.pin_out;
    assign o_pin_oe_n = cur.pin_oe_n;

endmodule

// ---- deep_stop_pkg.sv ----
// shared modes, configuration carrier and timing constants of the stop sequencer
package deep_stop_pkg;

    // operating modes of the sequencer
    typedef enum logic [2:0] {
        mode_run,
        mode_light_stop,
        mode_ram_retain_stop,
        mode_deepest_stop,
        mode_restart
    } power_mode_t;

    // stop-relevant configuration, captured when a stop is entered
    typedef struct packed {
        logic background_debug_enable;
        logic low_voltage_detector_enable;
        logic low_voltage_detector_stop_enable;
        logic converter_async_clock_enable;
        logic internal_ref_clock_enable;
        logic internal_ref_stop_enable;
        logic external_ref_clock_enable;
        logic external_ref_stop_enable;
        logic external_high_range;
    } stop_cfg_t;

    // power and clock controls driven out of the block
    typedef struct packed {
        logic core_power;
        logic ram_power;
        logic regulator_power;
        logic regulator_full;
        logic periph_clock_enable;
        logic debug_clock_enable;
        logic converter_run;
        logic internal_ref_run;
        logic external_osc_run;
    } power_ctl_t;

    // bus clock period and restart hold time
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESTART_HOLD_NS = 1000;
    localparam int RESTART_CYCLES_CALC = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_CYCLES = (RESTART_CYCLES_CALC < 1) ? 1 : RESTART_CYCLES_CALC;

    // default pin count and reset values
    localparam int PIN_COUNT = 12;
    localparam int RESTART_CNT_W = 8;
    localparam logic ACK_READ_VALUE = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic LATCH_RESET = 1'b0;
    localparam power_ctl_t POWER_CTL_RESET = '{
        core_power: 1'b1,
        ram_power: 1'b1,
        regulator_power: 1'b1,
        regulator_full: 1'b1,
        periph_clock_enable: 1'b1,
        debug_clock_enable: 1'b1,
        converter_run: 1'b0,
        internal_ref_run: 1'b0,
        external_osc_run: 1'b0
    };

endpackage

// ---- wake_pin_driver.sv ----
// outside wake source model: holds the wake pin high, low only to wake
`timescale 1ns/100ps
module wake_pin_driver (
    // wake request from the bench
    input wire logic i_wake_req,
    // pin level seen by the block
    output logic o_wake_pin_n
);
    // actively driven high; low only when a wake is wanted
    assign o_wake_pin_n = !i_wake_req;
endmodule

// ---- deep_stop_properties.sv ----
// concurrent checks on the stop sequencer ports
`timescale 1ns/100ps
module deep_stop_checker #(
    parameter int N_PINS = 12
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // stimulus seen
    input wire logic i_stop_execute,
    input wire logic i_stop_instruction_enable,
    input wire logic i_powerdown_control,
    input wire logic i_partial_powerdown_control,
    input wire deep_stop_pkg::stop_cfg_t i_stop_cfg,
    input wire logic i_wake_pin_n,
    input wire logic i_periodic_wake_timer_event,
    input wire logic i_periodic_wake_timer_irq_enable,
    input wire logic i_powerdown_acknowledge_write,
    input wire logic i_powerdown_acknowledge_data,
    // outputs watched
    input wire logic [2:0] o_mode,
    input wire logic o_system_reset,
    input wire logic o_illegal_opcode_reset,
    input wire logic o_lvd_reset_enable,
    input wire logic o_lvd_low_trip_select,
    input wire logic o_partial_powerdown_flag,
    input wire logic o_powerdown_flag,
    input wire logic o_pin_latch_closed,
    input wire deep_stop_pkg::power_ctl_t o_power_ctl,
    input wire logic o_wake_pin_pullup_enable,
    input wire logic [N_PINS-1:0] o_pin_oe_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    // helper terms: deep stop request taken in run, and deep stop held
    logic go_deep;
    logic in_deep;
    assign go_deep = o_mode == 3'h0 && i_stop_execute && i_stop_instruction_enable
        && i_powerdown_control && !i_stop_cfg.background_debug_enable
        && !(i_stop_cfg.low_voltage_detector_enable && i_stop_cfg.low_voltage_detector_stop_enable);
    assign in_deep = o_mode == 3'h2 || o_mode == 3'h3;

    // wake pin seen low long enough to pass the synchroniser
    sequence s_pin_low;
        (in_deep && !i_wake_pin_n)[*3];
    endsequence
    sequence s_timer_hit;
        in_deep && i_periodic_wake_timer_event && i_periodic_wake_timer_irq_enable;
    endsequence

    a_enter_ram_retain: assert property (
        go_deep && i_partial_powerdown_control |=> o_mode == 3'h2 && o_pin_latch_closed)
        else $error("ram retaining stop not entered");
    a_enter_deepest: assert property (
        go_deep && !i_partial_powerdown_control |=> o_mode == 3'h3 && (&o_pin_oe_n))
        else $error("deepest stop not entered");
    a_illegal_stop: assert property (
        o_mode == 3'h0 && i_stop_execute && !i_stop_instruction_enable
        |=> o_illegal_opcode_reset && o_mode == 3'h0)
        else $error("disabled stop not refused");
    a_pullup_off_deep: assert property (
        in_deep |-> !o_wake_pin_pullup_enable)
        else $error("wake pullup on in deep stop");
    a_periph_clk_gated: assert property (
        o_mode inside {3'h1, 3'h2, 3'h3} |-> !o_power_ctl.periph_clock_enable)
        else $error("peripheral clock running in stop");
    a_deepest_power: assert property (
        o_mode == 3'h3 |-> !o_power_ctl.ram_power && !o_power_ctl.regulator_power)
        else $error("power left on in deepest stop");
    a_retain_power: assert property (
        o_mode == 3'h2 |-> o_power_ctl.ram_power && !o_power_ctl.core_power)
        else $error("wrong power in ram retaining stop");
    a_timer_wake: assert property (
        s_timer_hit |=> o_mode == 3'h4 && o_system_reset)
        else $error("timer wake missed");
    a_pin_wake: assert property (
        s_pin_low |=> o_mode == 3'h4 && o_system_reset)
        else $error("pin wake missed");
    a_restart_lvd: assert property (
        o_system_reset |-> o_lvd_reset_enable && o_lvd_low_trip_select)
        else $error("low voltage reset not armed in restart");
    a_ack_clears: assert property (
        o_mode == 3'h0 && i_powerdown_acknowledge_write && i_powerdown_acknowledge_data
        |=> !o_partial_powerdown_flag && !o_powerdown_flag && !o_pin_latch_closed)
        else $error("acknowledge did not clear");
    a_ack_zero_inert: assert property (
        i_powerdown_acknowledge_write && !i_powerdown_acknowledge_data
        |=> $stable(o_partial_powerdown_flag) && $stable(o_pin_latch_closed))
        else $error("zero acknowledge had an effect");
endmodule

// ---- tb.sv ----
// bench for the stop sequencer: scenarios, checks and verdict
`timescale 1ns/100ps
module tb;
    localparam int NP = 12;
    localparam int RC = 2;
    logic i_clk, i_srst, i_stop_execute, i_stop_instruction_enable;
    logic i_powerdown_control, i_partial_powerdown_control, wake_req, i_wake_pin_n;
    logic i_wake_pin_pullup_request, i_periodic_wake_timer_event;
    logic i_periodic_wake_timer_irq_enable, i_light_stop_wake, i_low_voltage_detector_low;
    logic i_powerdown_acknowledge_write, i_powerdown_acknowledge_data;
    deep_stop_pkg::stop_cfg_t i_stop_cfg;
    logic [NP-1:0] i_port_data, i_port_direction, i_periph_enable, i_periph_data;
    logic [NP-1:0] i_periph_direction, o_pin_out, o_pin_oe_n;
    logic [2:0] o_mode;
    logic o_system_reset, o_illegal_opcode_reset, o_lvd_reset_enable, o_lvd_low_trip_select;
    logic o_partial_powerdown_flag, o_powerdown_flag, o_powerdown_acknowledge;
    logic o_pin_latch_closed, o_wake_pin_pullup_enable;
    deep_stop_pkg::power_ctl_t o_power_ctl;
    int errors;
    int checks_done;

    deep_stop_power_sequencer #(.N_PINS(NP), .RESTART_CYCLES(RC)) i_dut (.*);
    wake_pin_driver i_wake (.i_wake_req(wake_req), .o_wake_pin_n(i_wake_pin_n));

    // bench clock, 50 ns period
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // bounded wait for a mode
    task automatic wait_mode(input logic [2:0] m);
        int k;
        k = 0;
        while (o_mode !== m && k < 200)
        begin
            step(1);
            k++;
        end
        if (o_mode !== m)
        begin
            errors++;
            end_sim();
        end
    endtask

    // one-cycle stop request with the given selection
    task automatic do_stop(input logic powerdown_control, input logic partial_powerdown_control);
        i_powerdown_control = powerdown_control;
        i_partial_powerdown_control = partial_powerdown_control;
        i_stop_execute = 1'b1;
        step(1);
        i_stop_execute = 1'b0;
        step(1);
    endtask

    task automatic ack(input logic d);
        i_powerdown_acknowledge_data = d;
        i_powerdown_acknowledge_write = 1'b1;
        step(1);
        i_powerdown_acknowledge_write = 1'b0;
        step(1);
    endtask

    task automatic t_illegal();
        i_stop_instruction_enable = 1'b0;
        i_stop_execute = 1'b1;
        step(1);
        i_stop_execute = 1'b0;
        chk("illegal pulse", o_illegal_opcode_reset, 1);
        step(1);
        chk("mode after illegal", o_mode, 0);
        i_stop_instruction_enable = 1'b1;
    endtask

    task automatic t_ram_retain();
        int n;
        i_port_data = 12'h5a3;
        step(2);
        do_stop(1'b1, 1'b1);
        chk("retain mode", o_mode, 2);
        chk("latch", o_pin_latch_closed, 1);
        chk("retain power", {o_power_ctl.core_power, o_power_ctl.ram_power}, 2'b01);
        chk("pullup", o_wake_pin_pullup_enable, 0);
        chk("periph clk", o_power_ctl.periph_clock_enable, 0);
        i_port_data = 12'h000;
        step(2);
        chk("held pins", o_pin_out, 12'h5a3);
        wake_req = 1'b1;
        wait_mode(3'h4);
        wake_req = 1'b0;
        chk("partial flag", o_partial_powerdown_flag, 1);
        chk("restart lvd", {o_system_reset, o_lvd_reset_enable, o_lvd_low_trip_select}, 3'h7);
        n = 0;
        while (o_mode === 3'h4 && n < 50)
        begin
            n++;
            step(1);
        end
        chk("restart length", n, RC);
        chk("pins still held", o_pin_out, 12'h5a3);
        // partial restore, low nibble owned by peripherals
        i_port_data = 12'h0c3;
        i_port_direction = 12'hff0;
        i_periph_enable = 12'h00f;
        i_periph_data = 12'h005;
        i_periph_direction = 12'h003;
        ack(1'b0);
        chk("flag after zero ack", o_partial_powerdown_flag, 1);
        chk("ack reads", o_powerdown_acknowledge, 0);
        ack(1'b1);
        chk("flag after ack", {o_partial_powerdown_flag, o_pin_latch_closed}, 0);
        chk("pins opened", o_pin_out, 12'h0c5);
        chk("pin enables", o_pin_oe_n, 12'h00c);
    endtask

    task automatic t_deepest();
        i_periodic_wake_timer_irq_enable = 1'b0;
        do_stop(1'b1, 1'b0);
        chk("deep mode", o_mode, 3);
        chk("hi-z pins", o_pin_oe_n, 12'hfff);
        chk("deep power", {o_power_ctl.ram_power, o_power_ctl.regulator_power}, 0);
        chk("deep pullup", o_wake_pin_pullup_enable, 0);
        i_periodic_wake_timer_event = 1'b1;
        step(1);
        i_periodic_wake_timer_event = 1'b0;
        step(1);
        chk("masked timer", o_mode, 3);
        i_low_voltage_detector_low = 1'b1;
        i_periodic_wake_timer_irq_enable = 1'b1;
        i_periodic_wake_timer_event = 1'b1;
        step(1);
        i_periodic_wake_timer_event = 1'b0;
        chk("timer wake", o_mode, 4);
        chk("pd flag", o_powerdown_flag, 1);
        step(RC + 4);
        chk("held by low supply", o_system_reset, 1);
        i_low_voltage_detector_low = 1'b0;
        wait_mode(3'h0);
        chk("pd flag kept", o_powerdown_flag, 1);
        ack(1'b1);
        chk("pd flag cleared", o_powerdown_flag, 0);
    endtask

    // light stop keeps only the clocks whose enables allow it
    task automatic t_light(input logic powerdown_control, input logic [8:0] cfg, input logic [3:0] exp);
        i_stop_cfg = cfg;
        do_stop(powerdown_control, 1'b1);
        chk("light mode", o_mode, 1);
        chk("light clocks", {o_power_ctl.periph_clock_enable, o_power_ctl.converter_run,
            o_power_ctl.internal_ref_run, o_power_ctl.external_osc_run}, exp);
        i_light_stop_wake = 1'b1;
        wait_mode(3'h0);
        i_light_stop_wake = 1'b0;
        step(1);
    endtask

    // main sequence
    initial
    begin
        errors = 0;
        checks_done = 0;
        i_srst = 1'b1;
        {i_stop_execute, i_powerdown_control, i_partial_powerdown_control, wake_req} = 4'h0;
        i_stop_instruction_enable = 1'b1;
        i_wake_pin_pullup_request = 1'b1;
        {i_periodic_wake_timer_event, i_periodic_wake_timer_irq_enable} = 2'h0;
        {i_light_stop_wake, i_low_voltage_detector_low} = 2'h0;
        {i_powerdown_acknowledge_write, i_powerdown_acknowledge_data} = 2'h0;
        i_stop_cfg = '0;
        {i_port_data, i_periph_enable, i_periph_data, i_periph_direction} = '0;
        i_port_direction = 12'hfff;
        step(2);
        chk("reset power", o_power_ctl, deep_stop_pkg::POWER_CTL_RESET);
        chk("reset pins", o_pin_oe_n, 12'hfff);
        chk("reset flags", {o_partial_powerdown_flag, o_powerdown_flag, o_mode}, 0);
        i_srst = 1'b0;
        step(3);
        t_illegal();
        t_ram_retain();
        t_deepest();
        t_light(1'b1, 9'h1ff, 4'b0111);
        t_light(1'b1, 9'h137, 4'b0000);
        // detector armed for stop, then powerdown control clear
        t_light(1'b1, 9'h0f7, 4'b0101);
        t_light(1'b0, 9'h038, 4'b0010);
        end_sim();
    end
endmodule

bind deep_stop_power_sequencer deep_stop_checker #(.N_PINS(N_PINS)) i_chk (.*);
